// ==== ack_delay_timer.sv ====
// One-shot ACK interrupt countdown in 1.024 us ticks
`timescale 1ns/1ps
module ack_delay_timer (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  // Control
  input wire logic ack_in,
  input wire logic [rx_desc_pkg::DELAY_W-1:0] delay,
  // Status
  output logic busy,
  output logic fire
);
  import rx_desc_pkg::*;
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);
  typedef struct packed {
    ack_state_t st;
    logic [DELAY_W-1:0] cnt;
    logic [TICK_W-1:0] presc;
    logic fire;
  } timer_state_t;
  timer_state_t s;
  timer_state_t next_s;

  ////////////////////////////////////////////////////////////////////////////////
  // Countdown
  always_comb begin
    next_s = s;
    if (ce) begin
      next_s.fire = 1'b0;
      case (s.st)
        ACK_IDLE: begin
          if (ack_in) begin
            if (delay == '0) begin
              next_s.fire = 1'b1;
            end else begin
              next_s.st = ACK_RUN;
              next_s.cnt = delay;
              next_s.presc = '0;
            end
          end
        end
        ACK_RUN: begin
          if (s.presc == TICK_LAST) begin
            next_s.presc = '0;
            if (s.cnt == DELAY_W'(1)) begin
              next_s.fire = 1'b1;
              next_s.st = ACK_IDLE;
            end else begin
              next_s.cnt = s.cnt - DELAY_W'(1);
            end
          end else begin
            next_s.presc = s.presc + TICK_W'(1);
          end
        end
        default: begin
          next_s.st = ACK_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign busy = (s.st == ACK_RUN);
  assign fire = s.fire;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_ack_load;
    ce && s.st == ACK_IDLE && ack_in && delay != '0;
  endsequence

  a_ack_no_early: assert property (s_ack_load |=> !s.fire [*8])
    else $error("ack interrupt fired before the countdown expired");
  a_ack_no_reload: assert property (ce && s.st == ACK_RUN && ack_in && s.presc != TICK_LAST
    |=> s.cnt == $past(s.cnt))
    else $error("ack countdown reloaded while running");
  a_tick_wrap: assert property (ce && s.st == ACK_RUN && s.presc == TICK_LAST
    |=> s.presc == '0 && (s.cnt == $past(s.cnt) - DELAY_W'(1) || s.fire))
    else $error("tick did not step the countdown");
endmodule

// ==== dma_partner.sv ====
// Descriptor DMA engine and host memory stand-in facing the threshold block
`timescale 1ns/1ps
module dma_partner (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Requests from the block
  input wire rx_desc_pkg::dma_req_t dma_req,
  // Levels chosen by the test
  input wire rx_desc_pkg::dma_stat_t stat_set,
  // Status towards the block
  output rx_desc_pkg::dma_stat_t dma_stat,
  output logic [15:0] req_cycles
);
  import rx_desc_pkg::*;
  ////////////////////////////////////////////////////////////////////////////////
  // Registered counts and request tally
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dma_stat <= '0;
      req_cycles <= 16'h0000;
    end else begin
      dma_stat <= stat_set;
      if (dma_req.prefetch || dma_req.writeback) begin
        req_cycles <= req_cycles + 16'h0001;
      end
    end
  end
endmodule

// ==== rx_desc_pkg.sv ====
// Shared constants and types for the receive descriptor threshold block
package rx_desc_pkg;
  ////////////////////////////////////////////////////////////////////////////////
  // Register byte offsets
  localparam logic [15:0] OFS_FETCH_CTRL = 16'h2928;
  localparam logic [15:0] OFS_SMALL_SIZE = 16'h2c00;
  localparam logic [15:0] OFS_ACK_DELAY = 16'h2c08;
  localparam logic [15:0] OFS_IRQ_STATUS = 16'h2c20;
  localparam logic [15:0] OFS_IRQ_CLEAR = 16'h2c24;
  localparam logic [15:0] OFS_IRQ_ENABLE = 16'h2c28;
  localparam logic [15:0] OFS_DMA_STATUS = 16'h2c2c;
  ////////////////////////////////////////////////////////////////////////////////
  // Field positions and widths
  localparam int THR_W = 6;
  localparam int PTHR_LSB = 0;
  localparam int HTHR_LSB = 8;
  localparam int WTHR_LSB = 16;
  localparam int UNIT_BIT = 24;
  localparam int SIZE_W = 12;
  localparam int DELAY_W = 16;
  localparam int PKT_LEN_W = 16;
  localparam int CNT_W = 8;
  localparam int THR_D_W = 12;
  localparam int IRQ_W = 2;
  localparam int IRQ_SMALL = 0;
  localparam int IRQ_ACK = 1;
  localparam int DSTAT_ONCHIP_LSB = 0;
  localparam int DSTAT_HOST_LSB = 8;
  localparam int DSTAT_READY_LSB = 16;
  localparam int DSTAT_FETCH_BIT = 24;
  localparam int DSTAT_WB_BIT = 25;
  localparam int DSTAT_ACK_BUSY_BIT = 26;
  ////////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [THR_W-1:0] PTHR_RST = 6'h00;
  localparam logic [THR_W-1:0] HTHR_RST = 6'h00;
  localparam logic [THR_W-1:0] WTHR_RST = 6'h01;
  localparam logic UNIT_RST = 1'b1;
  localparam logic [SIZE_W-1:0] SIZE_RST = 12'h000;
  localparam logic [DELAY_W-1:0] DELAY_RST = 16'h0000;
  ////////////////////////////////////////////////////////////////////////////////
  // Sizes and timing
  localparam int DESC_BYTES = 16;
  localparam int CACHE_LINE_BYTES = 64;
  localparam logic [PKT_LEN_W-1:0] VLAN_TAG_BYTES = 16'h0004;
  localparam int CLK_PERIOD_PS = 25000;
  localparam int TICK_PS = 1024000;
  localparam int TICK_CYCLES = (TICK_PS + CLK_PERIOD_PS / 2) / CLK_PERIOD_PS;
  localparam int TICK_W = $clog2(TICK_CYCLES);
  ////////////////////////////////////////////////////////////////////////////////
  // Types
  typedef struct packed {
    logic unit;
    logic [THR_W-1:0] wthr;
    logic [THR_W-1:0] hthr;
    logic [THR_W-1:0] pthr;
  } fetch_ctrl_t;
  typedef struct packed {
    logic valid;
    logic [PKT_LEN_W-1:0] len;
    logic vlan_stripped;
    logic is_ack;
  } rx_pkt_t;
  typedef struct packed {
    logic [CNT_W-1:0] onchip_cnt;
    logic [CNT_W-1:0] host_cnt;
    logic [CNT_W-1:0] ready_cnt;
    logic busy;
    logic flush;
  } dma_stat_t;
  typedef struct packed {
    logic prefetch;
    logic writeback;
    logic writeback_all;
  } dma_req_t;
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_RD_WAIT = 2'b01,
    BUS_RD_DONE = 2'b11,
    BUS_WR = 2'b10
  } bus_state_t;
  typedef enum logic {
    ACK_IDLE = 1'b0,
    ACK_RUN = 1'b1
  } ack_state_t;
endpackage

// ==== rx_desc_threshold_and_irq_timing.sv ====
// Receive descriptor thresholds, small-frame and ACK interrupt timing, AHB-Lite registers
`timescale 1ns/1ps
// Behaviour
// - Host threshold is six bits at 13:8 of fetch control.
// - Prefetch needs host threshold met, no priority DMA, on-chip count under low.
// - Write-back threshold at 21:16 resets to one, compared with ready count.
// - Without flush, write back only when ready count exceeds the threshold, unless the threshold is one.
// - Write-back threshold one writes back once one cache line is ready.
// - Bit 24, reset one, picks descriptors or cache lines for thresholds.
// - Reserved fields read zero; software writes zero there.
// - Packets at or below the 12-bit size limit raise the small interrupt.
// - Size in bytes with headers and CRC, minus a stripped VLAN tag.
// - ACK delay is sixteen bits in steps of 1.024 us.
// - Unmasked ACK loads a countdown; interrupt only when it expires. A zero delay loads no countdown and interrupts at once.
// - ACK during a running countdown does not reload it.
// - Low threshold at 5:0; fetch considered only below it.
// - Descriptor units write back every descriptor.
module rx_desc_threshold_and_irq_timing #(
  parameter int LINE_DESC = rx_desc_pkg::CACHE_LINE_BYTES / rx_desc_pkg::DESC_BYTES
) (
  // Clock, reset, enable
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Receive parser
  input wire rx_desc_pkg::rx_pkt_t rx_pkt,
  // Descriptor DMA engine
  input wire rx_desc_pkg::dma_stat_t dma_stat,
  output rx_desc_pkg::dma_req_t dma_req,
  // Interrupt
  output logic irq
);
  import rx_desc_pkg::*;
  localparam logic [THR_D_W-1:0] LINE_D = THR_D_W'(LINE_DESC);
  typedef struct packed {
    bus_state_t bus;
    logic [15:0] addr;
    logic [31:0] rdata;
    fetch_ctrl_t fetch;
    logic [SIZE_W-1:0] size_limit;
    logic [DELAY_W-1:0] ack_delay;
    logic [IRQ_W-1:0] status;
    logic [IRQ_W-1:0] enable;
    dma_req_t req;
  } main_state_t;
  main_state_t s;
  main_state_t next_s;
  logic small_hit;
  logic ack_fire;
  logic ack_busy;
  logic ack_in;
  logic [IRQ_W-1:0] clr;
  logic [IRQ_W-1:0] set;
  logic [THR_D_W-1:0] pthr_d;
  logic [THR_D_W-1:0] hthr_d;
  logic [THR_D_W-1:0] wthr_d;
  logic [THR_D_W-1:0] onchip_d;
  logic [THR_D_W-1:0] host_d;
  logic [THR_D_W-1:0] ready_d;
  logic fetch_ok;
  logic wb_ok;
  logic addr_take;

  ////////////////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic [THR_D_W-1:0] thr_desc(input logic [THR_W-1:0] thr,
                                                 input logic unit);
    thr_desc = unit ? THR_D_W'(thr) : THR_D_W'(thr * LINE_DESC);
  endfunction

  function automatic logic [31:0] reg_read(input logic [15:0] addr, input main_state_t st,
                                           input dma_stat_t ds, input logic abusy);
    reg_read = '0;
    case (addr)
      OFS_FETCH_CTRL: begin
        reg_read[PTHR_LSB +: THR_W] = st.fetch.pthr;
        reg_read[HTHR_LSB +: THR_W] = st.fetch.hthr;
        reg_read[WTHR_LSB +: THR_W] = st.fetch.wthr;
        reg_read[UNIT_BIT] = st.fetch.unit;
      end
      OFS_SMALL_SIZE: begin
        reg_read[SIZE_W-1:0] = st.size_limit;
      end
      OFS_ACK_DELAY: begin
        reg_read[DELAY_W-1:0] = st.ack_delay;
      end
      OFS_IRQ_STATUS: begin
        reg_read[IRQ_W-1:0] = st.status;
      end
      OFS_IRQ_ENABLE: begin
        reg_read[IRQ_W-1:0] = st.enable;
      end
      OFS_DMA_STATUS: begin
        reg_read[DSTAT_ONCHIP_LSB +: CNT_W] = ds.onchip_cnt;
        reg_read[DSTAT_HOST_LSB +: CNT_W] = ds.host_cnt;
        reg_read[DSTAT_READY_LSB +: CNT_W] = ds.ready_cnt;
        reg_read[DSTAT_FETCH_BIT] = st.req.prefetch;
        reg_read[DSTAT_WB_BIT] = st.req.writeback;
        reg_read[DSTAT_ACK_BUSY_BIT] = abusy;
      end
      default: begin
        reg_read = '0;
      end
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Event sources
  small_frame_detect u_small (
    .hclk(hclk),
    .hresetn(hresetn),
    .ce(ce),
    .rx_pkt(rx_pkt),
    .size_limit(s.size_limit),
    .hit(small_hit)
  );

  assign ack_in = rx_pkt.valid && rx_pkt.is_ack && s.enable[IRQ_ACK];

  ack_delay_timer u_ack (
    .hclk(hclk),
    .hresetn(hresetn),
    .ce(ce),
    .ack_in(ack_in),
    .delay(s.ack_delay),
    .busy(ack_busy),
    .fire(ack_fire)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Threshold evaluation
  assign pthr_d = thr_desc(s.fetch.pthr, s.fetch.unit);
  assign hthr_d = thr_desc(s.fetch.hthr, s.fetch.unit);
  assign wthr_d = thr_desc(s.fetch.wthr, s.fetch.unit);
  assign onchip_d = THR_D_W'(dma_stat.onchip_cnt);
  assign host_d = THR_D_W'(dma_stat.host_cnt);
  assign ready_d = THR_D_W'(dma_stat.ready_cnt);
  assign fetch_ok = (host_d >= hthr_d) && !dma_stat.busy && (onchip_d < pthr_d);
  always_comb begin
    wb_ok = dma_stat.flush && (ready_d != '0);
    if (s.fetch.wthr == THR_W'(1)) begin
      wb_ok = wb_ok || (ready_d >= LINE_D);
    end else begin
      wb_ok = wb_ok || (ready_d > wthr_d);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Bus, registers and interrupt state
  assign hreadyout = ce && (s.bus != BUS_RD_WAIT);
  assign hresp = 1'b0;
  assign hrdata = s.rdata;
  assign addr_take = hreadyout && hready && hsel && htrans[1];

  always_comb begin
    next_s = s;
    clr = '0;
    set = '0;
    set[IRQ_SMALL] = small_hit;
    set[IRQ_ACK] = ack_fire;
    if (ce) begin
      case (s.bus)
        BUS_WR: begin
          next_s.bus = BUS_IDLE;
          case (s.addr)
            OFS_FETCH_CTRL: begin
              next_s.fetch.pthr = hwdata[PTHR_LSB +: THR_W];
              next_s.fetch.hthr = hwdata[HTHR_LSB +: THR_W];
              next_s.fetch.wthr = hwdata[WTHR_LSB +: THR_W];
              next_s.fetch.unit = hwdata[UNIT_BIT];
            end
            OFS_SMALL_SIZE: begin
              next_s.size_limit = hwdata[SIZE_W-1:0];
            end
            OFS_ACK_DELAY: begin
              next_s.ack_delay = hwdata[DELAY_W-1:0];
            end
            OFS_IRQ_CLEAR: begin
              clr = hwdata[IRQ_W-1:0];
            end
            OFS_IRQ_ENABLE: begin
              next_s.enable = hwdata[IRQ_W-1:0];
            end
            default: begin
              next_s.enable = s.enable;
            end
          endcase
        end
        BUS_RD_WAIT: begin
          next_s.rdata = reg_read(s.addr, s, dma_stat, ack_busy);
          next_s.bus = BUS_RD_DONE;
        end
        BUS_RD_DONE: begin
          next_s.bus = BUS_IDLE;
        end
        BUS_IDLE: begin
          next_s.bus = BUS_IDLE;
        end
        default: begin
          next_s.bus = BUS_IDLE;
        end
      endcase
      if (addr_take) begin
        next_s.addr = haddr[15:0];
        next_s.bus = hwrite ? BUS_WR : BUS_RD_WAIT;
      end
      next_s.status = (s.status & ~clr) | set;
      next_s.req.prefetch = fetch_ok;
      next_s.req.writeback = wb_ok;
      next_s.req.writeback_all = s.fetch.unit;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= '0;
      s.fetch.pthr <= PTHR_RST;
      s.fetch.hthr <= HTHR_RST;
      s.fetch.wthr <= WTHR_RST;
      s.fetch.unit <= UNIT_RST;
      s.size_limit <= SIZE_RST;
      s.ack_delay <= DELAY_RST;
    end else begin
      s <= next_s;
    end
  end

  assign dma_req = s.req;
  assign irq = |(s.status & s.enable);

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_small_pkt;
    ce && rx_pkt.valid && !rx_pkt.vlan_stripped && rx_pkt.len <= PKT_LEN_W'(s.size_limit);
  endsequence
  sequence s_small_vlan;
    ce && rx_pkt.valid && rx_pkt.vlan_stripped && s.size_limit != '0
      && rx_pkt.len == PKT_LEN_W'(s.size_limit) + VLAN_TAG_BYTES;
  endsequence
  sequence s_ack_now;
    ce && ack_in && !ack_busy && s.ack_delay == '0;
  endsequence
  sequence s_rd_addr;
    addr_take && !hwrite;
  endsequence

  a_small_irq: assert property (s_small_pkt ##1 ce |=> s.status[IRQ_SMALL])
    else $error("small packet did not set its status bit");
  a_small_vlan: assert property (s_small_vlan ##1 ce |=> s.status[IRQ_SMALL])
    else $error("stripped tag counted in small packet size");
  a_fetch_busy: assert property (ce && dma_stat.busy |=> !dma_req.prefetch)
    else $error("prefetch issued while higher priority dma pending");
  a_fetch_low: assert property (ce && !dma_stat.busy && host_d >= hthr_d && onchip_d < pthr_d
    |=> dma_req.prefetch)
    else $error("prefetch missing below low threshold");
  a_wb_hold: assert property (ce && !dma_stat.flush && s.fetch.wthr != THR_W'(1)
    && ready_d <= wthr_d |=> !dma_req.writeback)
    else $error("write back before threshold exceeded");
  a_wb_line: assert property (ce && s.fetch.wthr == THR_W'(1) && ready_d >= LINE_D
    |=> dma_req.writeback)
    else $error("write back missing with one cache line ready");
  a_wb_all: assert property (hresetn && ce ##1 ce
    |-> dma_req.writeback_all == $past(s.fetch.unit))
    else $error("write back all does not follow unit select");
  a_rsv_zero: assert property (s.bus == BUS_RD_DONE && s.addr == OFS_FETCH_CTRL
    |-> hrdata[31:25] == '0 && hrdata[23:22] == '0 && hrdata[15:14] == '0
    && hrdata[7:6] == '0)
    else $error("reserved bits read nonzero");
  a_fetch_reset: assert property ($rose(hresetn) |-> s.fetch.wthr == WTHR_RST
    && s.fetch.unit == UNIT_RST)
    else $error("fetch control reset value wrong");
  a_ack_now: assert property (s_ack_now ##1 ce |=> s.status[IRQ_ACK])
    else $error("zero delay ack interrupt not immediate");
  a_read_wait: assert property (s_rd_addr |=> !hreadyout ##1 (hreadyout || !ce))
    else $error("read data phase timing wrong");
endmodule

// ==== rx_desc_threshold_and_irq_timing_tb.sv ====
// Self-checking testbench for the receive threshold and interrupt timing block
`timescale 1ns/1ps
module rx_desc_threshold_and_irq_timing_tb;
  import rx_desc_pkg::*;
  typedef struct packed {
    logic [31:0] ctrl;
    dma_stat_t st;
    dma_req_t exp;
  } row_t;
  // Control word, partner levels, expected prefetch/writeback/all
  localparam row_t ROWS [12] = '{
    '{32'h01010204, {8'h03, 8'h02, 8'h00, 2'h0}, 3'h5},
    '{32'h01010204, {8'h04, 8'h02, 8'h00, 2'h0}, 3'h1},
    '{32'h01010204, {8'h03, 8'h01, 8'h00, 2'h0}, 3'h1},
    '{32'h01010204, {8'h03, 8'h02, 8'h00, 2'h2}, 3'h1},
    '{32'h01030000, {8'h00, 8'h00, 8'h03, 2'h0}, 3'h1},
    '{32'h01030000, {8'h00, 8'h00, 8'h04, 2'h0}, 3'h3},
    '{32'h01030000, {8'h00, 8'h00, 8'h01, 2'h1}, 3'h3},
    '{32'h01010000, {8'h00, 8'h00, 8'h03, 2'h0}, 3'h1},
    '{32'h01010000, {8'h00, 8'h00, 8'h04, 2'h0}, 3'h3},
    '{32'h00020000, {8'h00, 8'h00, 8'h08, 2'h0}, 3'h0},
    '{32'h00020000, {8'h00, 8'h00, 8'h09, 2'h0}, 3'h2},
    '{32'h00000101, {8'h03, 8'h04, 8'h00, 2'h0}, 3'h4}
  };
  // Length, VLAN stripped, expected small hit
  localparam logic [17:0] SMALL [5] = '{
    {16'h0040, 1'b0, 1'b1},
    {16'h0041, 1'b0, 1'b0},
    {16'h0044, 1'b1, 1'b1},
    {16'h0045, 1'b1, 1'b0},
    {16'h0002, 1'b1, 1'b1}
  };
  logic hclk;
  logic hresetn;
  logic ce;
  logic hsel;
  logic hwrite;
  logic [1:0] htrans;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  logic hreadyout;
  logic hresp;
  logic irq;
  logic [31:0] hrdata;
  rx_pkt_t rx_pkt;
  dma_stat_t stat_set;
  dma_stat_t dma_stat;
  dma_req_t dma_req;
  logic [15:0] req_cycles;
  int err_count;
  int checks;
  ////////////////////////////////////////////////////////////////////////////////
  // Design and partner
  rx_desc_threshold_and_irq_timing #(.LINE_DESC(4)) dut (
    .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .rx_pkt(rx_pkt), .dma_stat(dma_stat), .dma_req(dma_req), .irq(irq)
  );
  dma_partner partner (
    .hclk(hclk), .hresetn(hresetn), .dma_req(dma_req), .stat_set(stat_set),
    .dma_stat(dma_stat), .req_cycles(req_cycles)
  );
  ////////////////////////////////////////////////////////////////////////////////
  // Tasks
  task automatic end_of_test;
    if (err_count == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t mismatch got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 20);
    if (hreadyout !== 1'b1) begin
      err_count++;
      $display("[ERR] %0t bus wait timed out", $time);
      end_of_test();
    end
  endtask
  task automatic ahb(input logic [15:0] a, input logic w, input logic [31:0] d,
                     output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= {16'h0000, a};
    htrans <= 2'h2;
    hwrite <= w;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    r = hrdata;
    chk({31'h0, hresp}, 32'h00000000);
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    logic [31:0] r;
    ahb(a, 1'b1, d, r);
  endtask
  task automatic rd_chk(input logic [15:0] a, input logic [31:0] e);
    logic [31:0] r;
    ahb(a, 1'b0, 32'h00000000, r);
    chk(r, e);
  endtask
  task automatic pkt(input logic [15:0] len, input logic strip, input logic ack);
    rx_pkt <= '{1'b1, len, strip, ack};
    @(posedge hclk);
    rx_pkt <= '0;
    @(posedge hclk);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Clock and watchdog
  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end
  initial begin
    repeat (100000) @(posedge hclk);
    err_count++;
    end_of_test();
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    err_count = 0;
    checks = 0;
    hresetn = 1'b0;
    ce = 1'b1;
    hsel = 1'b0;
    haddr = 32'h00000000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h00000000;
    rx_pkt = '0;
    stat_set = '0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    // Reset values
    rd_chk(OFS_FETCH_CTRL, 32'h01010000);
    rd_chk(OFS_SMALL_SIZE, 32'h00000000);
    rd_chk(OFS_ACK_DELAY, 32'h00000000);
    rd_chk(OFS_IRQ_STATUS, 32'h00000000);
    rd_chk(OFS_IRQ_ENABLE, 32'h00000000);
    // Field widths, reserved bits, unmapped and read-only places
    wr(OFS_FETCH_CTRL, 32'h013f3f3f);
    rd_chk(OFS_FETCH_CTRL, 32'h013f3f3f);
    wr(OFS_SMALL_SIZE, 32'h00000fff);
    rd_chk(OFS_SMALL_SIZE, 32'h00000fff);
    wr(OFS_ACK_DELAY, 32'h0000ffff);
    rd_chk(OFS_ACK_DELAY, 32'h0000ffff);
    wr(16'h2c04, 32'hffffffff);
    rd_chk(16'h2c04, 32'h00000000);
    wr(OFS_IRQ_STATUS, 32'h00000003);
    rd_chk(OFS_IRQ_STATUS, 32'h00000000);
    rd_chk(OFS_IRQ_CLEAR, 32'h00000000);
    // Prefetch and write-back decisions
    for (int i = 0; i < 12; i++) begin
      wr(OFS_FETCH_CTRL, ROWS[i].ctrl);
      stat_set <= ROWS[i].st;
      repeat (4) @(posedge hclk);
      chk({29'h0, dma_req}, {29'h0, ROWS[i].exp});
    end
    chk({31'h0, req_cycles !== 16'h0000}, 32'h00000001);
    // Small frame interrupt
    wr(OFS_SMALL_SIZE, 32'h00000040);
    wr(OFS_IRQ_ENABLE, 32'h00000001);
    for (int i = 0; i < 5; i++) begin
      pkt(SMALL[i][17:2], SMALL[i][1], 1'b0);
      rd_chk(OFS_IRQ_STATUS, {31'h0, SMALL[i][0]});
      chk({31'h0, irq}, {31'h0, SMALL[i][0]});
      wr(OFS_IRQ_CLEAR, 32'h00000001);
    end
    wr(OFS_IRQ_ENABLE, 32'h00000000);
    pkt(16'h0010, 1'b0, 1'b0);
    rd_chk(OFS_IRQ_STATUS, 32'h00000001);
    chk({31'h0, irq}, 32'h00000000);
    wr(OFS_IRQ_CLEAR, 32'h00000001);
    rd_chk(OFS_IRQ_STATUS, 32'h00000000);
    // ACK interrupt delay
    wr(OFS_IRQ_ENABLE, 32'h00000002);
    wr(OFS_ACK_DELAY, 32'h00000000);
    pkt(16'h0100, 1'b0, 1'b1);
    rd_chk(OFS_IRQ_STATUS, 32'h00000002);
    wr(OFS_IRQ_CLEAR, 32'h00000002);
    wr(OFS_IRQ_ENABLE, 32'h00000000);
    wr(OFS_ACK_DELAY, 32'h00000002);
    pkt(16'h0100, 1'b0, 1'b1);
    repeat (3 * TICK_CYCLES) @(posedge hclk);
    rd_chk(OFS_IRQ_STATUS, 32'h00000000);
    wr(OFS_IRQ_ENABLE, 32'h00000002);
    pkt(16'h0100, 1'b0, 1'b1);
    repeat (37) @(posedge hclk);
    pkt(16'h0100, 1'b0, 1'b1);
    repeat (2 * TICK_CYCLES - 40) @(posedge hclk);
    #1;
    chk({31'h0, irq}, 32'h00000000);
    @(posedge hclk);
    #1;
    chk({31'h0, irq}, 32'h00000001);
    @(posedge hclk);
    wr(OFS_IRQ_CLEAR, 32'h00000002);
    rd_chk(OFS_IRQ_STATUS, 32'h00000000);
    chk({31'h0, irq}, 32'h00000000);
    // Clock enable low freezes the countdown
    wr(OFS_ACK_DELAY, 32'h00000001);
    pkt(16'h0100, 1'b0, 1'b1);
    ce <= 1'b0;
    repeat (TICK_CYCLES + 8) @(posedge hclk);
    ce <= 1'b1;
    repeat (TICK_CYCLES - 8) @(posedge hclk);
    #1;
    chk({31'h0, irq}, 32'h00000000);
    repeat (10) @(posedge hclk);
    #1;
    chk({31'h0, irq}, 32'h00000001);
    end_of_test();
  end
endmodule

// ==== small_frame_detect.sv ====
// Small received frame detector
`timescale 1ns/1ps
module small_frame_detect (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  // Packet and limit
  input wire rx_desc_pkg::rx_pkt_t rx_pkt,
  input wire logic [rx_desc_pkg::SIZE_W-1:0] size_limit,
  // Detection pulse
  output logic hit
);
  import rx_desc_pkg::*;
  typedef struct packed {
    logic hit;
  } small_state_t;
  small_state_t s;
  small_state_t next_s;
  logic [PKT_LEN_W-1:0] eff_len;

  ////////////////////////////////////////////////////////////////////////////////
  // Size without a stripped tag, CRC kept
  always_comb begin
    next_s = s;
    eff_len = rx_pkt.len;
    if (rx_pkt.vlan_stripped) begin
      eff_len = (rx_pkt.len > VLAN_TAG_BYTES) ? rx_pkt.len - VLAN_TAG_BYTES : '0;
    end
    if (ce) begin
      next_s.hit = rx_pkt.valid && (eff_len <= PKT_LEN_W'(size_limit));
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign hit = s.hit;
endmodule
